// ===== rtl/wkt_top.sv
`default_nettype none
module wkt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        osc_clk_in,
  input  wire logic        xtal_clk_in,
  input  wire logic        uart_clk_in,
  input  wire logic        core_clk_stopped,
  input  wire logic [31:0] system_interrupt_enable,
  input  wire logic        capture_req,
  output logic             irq
);

  typedef struct packed {
    logic [31:0]                load;
    logic [31:0]                count;
    logic [31:0]                control;
    logic                       flag_wrap;
    logic                       flag_capt;
    logic [wkt_pkg::STAT_W-1:0] int_en;
    logic [31:0]                capture;
    logic                       cap_req_d;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic                       irq;
  } wkt_state_s;

  wkt_state_s q_r;
  wkt_state_s q_nxt;

  logic                              run;
  logic                              tick;
  logic                              step_wrap;
  logic [31:0]                       step_nxt;
  logic                              bus_wr;
  logic                              bus_setup;
  logic                              clr_wr;
  logic                              wrap_evt;
  logic [wkt_pkg::CTL_FMT_W-1:0]     fmt;
  logic [wkt_pkg::STAT_W-1:0]        status;

  function automatic logic wkt_addr_known(input logic [31:0] a);
    case (a)
      wkt_pkg::LOAD_ADDR, wkt_pkg::COUNT_ADDR, wkt_pkg::CONTROL_ADDR, wkt_pkg::CLEAR_ADDR,
      wkt_pkg::STATUS_ADDR, wkt_pkg::INT_CLEAR_ADDR, wkt_pkg::INT_EN_ADDR,
      wkt_pkg::CAPTURE_ADDR: wkt_addr_known = 1'b1;
      default:               wkt_addr_known = 1'b0;
    endcase
  endfunction : wkt_addr_known

  assign run       = q_r.control[wkt_pkg::CTL_EN_BIT];
  assign fmt       = q_r.control[wkt_pkg::CTL_FMT_LSB +: wkt_pkg::CTL_FMT_W];
  assign status    = {q_r.flag_capt, q_r.flag_wrap};
  assign pready    = psel & penable & ce;
  assign bus_wr    = pready & pwrite;
  assign bus_setup = psel & ~penable;
  assign clr_wr    = bus_wr && (paddr == wkt_pkg::CLEAR_ADDR);
  assign wrap_evt  = tick && run && step_wrap;

  wkt_tick_gen u_tick (
    .pclk             (pclk),
    .presetn          (presetn),
    .ce               (ce),
    .osc_clk_in       (osc_clk_in),
    .xtal_clk_in      (xtal_clk_in),
    .uart_clk_in      (uart_clk_in),
    .core_clk_stopped (core_clk_stopped),
    .src_sel          (q_r.control[wkt_pkg::CTL_SRC_LSB +: wkt_pkg::CTL_SRC_W]),
    .prescale         (q_r.control[wkt_pkg::CTL_PRE_LSB +: wkt_pkg::CTL_PRE_W]),
    .run              (run),
    .tick             (tick)
  );

  wkt_count_step u_step (
    .count     (q_r.count),
    .up        (q_r.control[wkt_pkg::CTL_UP_BIT]),
    .fmt       (fmt),
    .count_nxt (step_nxt),
    .wrap      (step_wrap)
  );

  always_comb begin
    q_nxt = q_r;
    if (bus_wr) begin
      case (paddr)
        wkt_pkg::LOAD_ADDR:    q_nxt.load    = pwdata;
        wkt_pkg::CONTROL_ADDR: q_nxt.control = pwdata & wkt_pkg::CTL_WMASK;
        wkt_pkg::INT_CLEAR_ADDR: begin
          if (pwdata[wkt_pkg::STAT_WRAP_BIT]) begin
            q_nxt.flag_wrap = 1'b0;
          end
          if (pwdata[wkt_pkg::STAT_CAPT_BIT]) begin
            q_nxt.flag_capt = 1'b0;
          end
        end
        wkt_pkg::INT_EN_ADDR:  q_nxt.int_en  = pwdata[wkt_pkg::STAT_W-1:0];
        default:               q_nxt.int_en  = q_r.int_en; // Count writes are ignored
      endcase
    end
    if (clr_wr) begin
      q_nxt.count     = q_r.load;
      q_nxt.flag_wrap = 1'b0;
    end else if (tick && run) begin
      if (step_wrap && q_r.control[wkt_pkg::CTL_PERIODIC_BIT]) begin
        q_nxt.count = q_r.load;
      end else begin
        q_nxt.count = step_nxt;
      end
    end
    // Set wins over any clear in the same cycle
    if (wrap_evt) begin
      q_nxt.flag_wrap = 1'b1;
    end
    q_nxt.cap_req_d = capture_req;
    if (capture_req && !q_r.cap_req_d && system_interrupt_enable[wkt_pkg::SYS_IRQ_TIMER_BIT]) begin
      q_nxt.capture   = q_r.count;
      q_nxt.flag_capt = 1'b1;
    end
    if (bus_setup) begin
      q_nxt.pslverr = ~wkt_addr_known(paddr);
      case (paddr)
        wkt_pkg::LOAD_ADDR:    q_nxt.prdata = q_r.load;
        wkt_pkg::COUNT_ADDR:   q_nxt.prdata = q_r.count;
        wkt_pkg::CONTROL_ADDR: q_nxt.prdata = q_r.control;
        wkt_pkg::STATUS_ADDR:  q_nxt.prdata = {30'h00000000, status};
        wkt_pkg::INT_EN_ADDR:  q_nxt.prdata = {30'h00000000, q_r.int_en};
        wkt_pkg::CAPTURE_ADDR: q_nxt.prdata = q_r.capture;
        default:               q_nxt.prdata = wkt_pkg::WORD_RESET;
      endcase
    end
    q_nxt.irq = |({q_nxt.flag_capt, q_nxt.flag_wrap} & q_nxt.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign prdata  = q_r.prdata;
  assign pslverr = q_r.pslverr;
  assign irq     = q_r.irq;

  property p_count_up;
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && run && q_r.control[wkt_pkg::CTL_UP_BIT] && fmt == wkt_pkg::FMT_BIN && !clr_wr
     && q_r.count != 32'hffffffff) |=> q_r.count == $past(q_r.count) + 32'h00000001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("Up count did not add one");

  property p_count_down;
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && run && !q_r.control[wkt_pkg::CTL_UP_BIT] && fmt == wkt_pkg::FMT_BIN && !clr_wr
     && q_r.count != 32'h00000000) |=> q_r.count == $past(q_r.count) - 32'h00000001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("Down count did not subtract one");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (ce && !run && !clr_wr) |=> $stable(q_r.count);
  endproperty
  a_halt: assert property (p_halt) else $error("Count moved while disabled");

  property p_periodic_reload;
    @(posedge pclk) disable iff (!presetn)
    (ce && wrap_evt && q_r.control[wkt_pkg::CTL_PERIODIC_BIT] && !clr_wr) |=> q_r.count == $past(q_r.load);
  endproperty
  a_periodic_reload: assert property (p_periodic_reload) else $error("Periodic wrap did not reload");

  property p_hund_range;
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && run && fmt[1] && !clr_wr && !step_wrap
     && q_r.count[wkt_pkg::HUND_LSB +: wkt_pkg::FIELD_W] <= wkt_pkg::HUND_MAX)
    |=> q_r.count[wkt_pkg::HUND_LSB +: wkt_pkg::FIELD_W] <= wkt_pkg::HUND_MAX;
  endproperty
  a_hund_range: assert property (p_hund_range) else $error("Hundredths left 0 to 99");

  property p_clear_reload;
    @(posedge pclk) disable iff (!presetn)
    (ce && clr_wr) |=> q_r.count == $past(q_r.load);
  endproperty
  a_clear_reload: assert property (p_clear_reload) else $error("Clear write did not reload count");

  property p_clear_flag;
    @(posedge pclk) disable iff (!presetn)
    (ce && clr_wr && !wrap_evt) |=> !q_r.flag_wrap ##1 (q_r.flag_wrap == $past(wrap_evt && ce));
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("Clear write left interrupt pending");

  property p_capture_gate;
    @(posedge pclk) disable iff (!presetn)
    (ce && !system_interrupt_enable[wkt_pkg::SYS_IRQ_TIMER_BIT]) |=> $stable(q_r.capture);
  endproperty
  a_capture_gate: assert property (p_capture_gate) else $error("Capture while timer interrupt disabled");

  property p_read_count;
    @(posedge pclk) disable iff (!presetn)
    (ce && bus_setup && !pwrite && paddr == wkt_pkg::COUNT_ADDR) |=> prdata == $past(q_r.count) && !pslverr;
  endproperty
  a_read_count: assert property (p_read_count) else $error("Count read returned wrong data");

  property p_wrap_flag;
    @(posedge pclk) disable iff (!presetn)
    (ce && wrap_evt) |=> q_r.flag_wrap ##0 (irq == q_r.int_en[wkt_pkg::STAT_WRAP_BIT] || q_r.flag_capt);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("Wrap did not raise the flag");

  property p_int_clear_wrap;
    @(posedge pclk) disable iff (!presetn)
    (ce && bus_wr
     && paddr == wkt_pkg::INT_CLEAR_ADDR
     && pwdata[wkt_pkg::STAT_WRAP_BIT]
     && !wrap_evt)
    |=> !q_r.flag_wrap;
  endproperty
  a_int_clear_wrap: assert property (p_int_clear_wrap) else $error("Wrap flag kept");

  property p_free_down_wrap;
    @(posedge pclk) disable iff (!presetn)
    (ce && wrap_evt && !clr_wr
     && !q_r.control[wkt_pkg::CTL_PERIODIC_BIT]
     && !q_r.control[wkt_pkg::CTL_UP_BIT]
     && fmt == wkt_pkg::FMT_BIN)
    |=> q_r.count == 32'hffffffff;
  endproperty
  a_free_down_wrap: assert property (p_free_down_wrap) else $error("Free wrap lost");

  property p_load_write;
    @(posedge pclk) disable iff (!presetn)
    (ce && bus_wr
     && paddr == wkt_pkg::LOAD_ADDR)
    |=> q_r.load == $past(pwdata);
  endproperty
  a_load_write: assert property (p_load_write) else $error("Load not stored");

  property p_ctl_write;
    @(posedge pclk) disable iff (!presetn)
    (ce && bus_wr
     && paddr == wkt_pkg::CONTROL_ADDR)
    |=> q_r.control ==
        ($past(pwdata) & wkt_pkg::CTL_WMASK);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("Control not stored");

  property p_count_ro;
    @(posedge pclk) disable iff (!presetn)
    (ce && bus_wr
     && paddr == wkt_pkg::COUNT_ADDR
     && !(tick && run))
    |=> $stable(q_r.count);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("Count write took");

  property p_hour_span;
    @(posedge pclk) disable iff (!presetn)
    (ce && tick && run
     && !clr_wr && !step_wrap
     && fmt == wkt_pkg::FMT_H23
     && q_r.count[wkt_pkg::HR_LSB +: wkt_pkg::FIELD_W] <= wkt_pkg::HR23_MAX)
    |=> q_r.count[wkt_pkg::HR_LSB +: wkt_pkg::FIELD_W]
        <= wkt_pkg::HR23_MAX;
  endproperty
  a_hour_span: assert property (p_hour_span) else $error("Hours out of span");

  property p_capture_take;
    @(posedge pclk) disable iff (!presetn)
    (ce && capture_req
     && !q_r.cap_req_d
     && system_interrupt_enable[wkt_pkg::SYS_IRQ_TIMER_BIT])
    |=> q_r.capture == $past(q_r.count)
        && q_r.flag_capt;
  endproperty
  a_capture_take: assert property (p_capture_take) else $error("Capture missed");

endmodule : wkt_top
`default_nettype wire

// ===== rtl/wkt_pkg.sv
`default_nettype none
package wkt_pkg;

  // Register byte addresses on the APB
  localparam logic [31:0] LOAD_ADDR      = 32'hffff0340;
  localparam logic [31:0] COUNT_ADDR     = 32'hffff0344;
  localparam logic [31:0] CONTROL_ADDR   = 32'hffff0348;
  localparam logic [31:0] CLEAR_ADDR     = 32'hffff034c;
  localparam logic [31:0] STATUS_ADDR    = 32'hffff0350;
  localparam logic [31:0] INT_CLEAR_ADDR = 32'hffff0354;
  localparam logic [31:0] INT_EN_ADDR    = 32'hffff0358;
  localparam logic [31:0] CAPTURE_ADDR   = 32'hffff035c;

  localparam logic [31:0] WORD_RESET     = 32'h00000000;

  // Control register layout
  localparam int          CTL_PRE_LSB      = 0;
  localparam int          CTL_PRE_W        = 4;
  localparam int          CTL_FMT_LSB      = 4;
  localparam int          CTL_FMT_W        = 2;
  localparam int          CTL_PERIODIC_BIT = 6;
  localparam int          CTL_EN_BIT       = 7;
  localparam int          CTL_UP_BIT       = 8;
  localparam int          CTL_SRC_LSB      = 9;
  localparam int          CTL_SRC_W        = 2;
  localparam logic [31:0] CTL_WMASK        = 32'h000007ff;

  // Clock source codes
  localparam logic [1:0]  SRC_OSC  = 2'h0;
  localparam logic [1:0]  SRC_CORE = 2'h1;
  localparam logic [1:0]  SRC_XTAL = 2'h2;
  localparam logic [1:0]  SRC_UART = 2'h3;

  // Count format codes
  localparam logic [1:0]  FMT_BIN  = 2'h0;
  localparam logic [1:0]  FMT_RSV  = 2'h1;
  localparam logic [1:0]  FMT_H23  = 2'h2;
  localparam logic [1:0]  FMT_H255 = 2'h3;

  // Time format fields
  localparam int          FIELD_W   = 8;
  localparam int          HUND_LSB  = 0;
  localparam int          SEC_LSB   = 8;
  localparam int          MIN_LSB   = 16;
  localparam int          HR_LSB    = 24;
  localparam logic [7:0]  HUND_MAX  = 8'h63;
  localparam logic [7:0]  SEC_MAX   = 8'h3b;
  localparam logic [7:0]  MIN_MAX   = 8'h3b;
  localparam logic [7:0]  HR23_MAX  = 8'h17;
  localparam logic [7:0]  HR255_MAX = 8'hff;

  // Status, interrupt clear and enable layout
  localparam int          STAT_W        = 2;
  localparam int          STAT_WRAP_BIT = 0;
  localparam int          STAT_CAPT_BIT = 1;

  // Timer bit of the system interrupt-enable register
  localparam int          SYS_IRQ_TIMER_BIT = 4;

  localparam int          PRE_CNT_W = 15;

  // Terminal count of the prescaler for a 4-bit code: divide by 2**code
  function automatic logic [PRE_CNT_W-1:0] wkt_div_mask(input logic [CTL_PRE_W-1:0] code);
    logic [31:0] full;
    full = (32'h00000001 << code) - 32'h00000001;
    wkt_div_mask = full[PRE_CNT_W-1:0];
  endfunction : wkt_div_mask

endpackage : wkt_pkg
`default_nettype wire

// ===== rtl/wkt_tick_gen.sv
`default_nettype none
module wkt_tick_gen (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               ce,
  input  wire logic                               osc_clk_in,
  input  wire logic                               xtal_clk_in,
  input  wire logic                               uart_clk_in,
  input  wire logic                               core_clk_stopped,
  input  wire logic [wkt_pkg::CTL_SRC_W-1:0]      src_sel,
  input  wire logic [wkt_pkg::CTL_PRE_W-1:0]      prescale,
  input  wire logic                               run,
  output logic                                    tick
);

  // Each sync chain: [0] first stage, [1] second stage, [2] delayed copy of [1]
  typedef struct packed {
    logic [2:0]                       osc;
    logic [2:0]                       xtal;
    logic [2:0]                       uart;
    logic [wkt_pkg::PRE_CNT_W-1:0]    pre_cnt;
    logic                             tick;
  } wkt_tick_s;

  wkt_tick_s q_r;
  wkt_tick_s q_nxt;
  logic      src_edge;

  always_comb begin
    q_nxt      = q_r;
    q_nxt.osc  = {q_r.osc[1:0], osc_clk_in};
    q_nxt.xtal = {q_r.xtal[1:0], xtal_clk_in};
    q_nxt.uart = {q_r.uart[1:0], uart_clk_in};
    case (src_sel)
      wkt_pkg::SRC_OSC:  src_edge = q_r.osc[1] & ~q_r.osc[2];
      wkt_pkg::SRC_CORE: src_edge = ~core_clk_stopped;
      wkt_pkg::SRC_XTAL: src_edge = q_r.xtal[1] & ~q_r.xtal[2];
      wkt_pkg::SRC_UART: src_edge = q_r.uart[1] & ~q_r.uart[2];
      default:           src_edge = 1'b0;
    endcase
    q_nxt.tick = 1'b0;
    if (!run) begin
      q_nxt.pre_cnt = '0;
    end else if (src_edge) begin
      if (q_r.pre_cnt >= wkt_pkg::wkt_div_mask(prescale)) begin
        q_nxt.pre_cnt = '0;
        q_nxt.tick    = 1'b1;
      end else begin
        q_nxt.pre_cnt = q_r.pre_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign tick = q_r.tick;

  property p_core_div1;
    @(posedge pclk) disable iff (!presetn)
    (ce && run && src_sel == wkt_pkg::SRC_CORE && prescale == 4'h0 && !core_clk_stopped) |=> tick;
  endproperty
  a_core_div1: assert property (p_core_div1) else $error("Core clock divide-by-1 gave no tick");

  property p_div16_gap;
    @(posedge pclk) disable iff (!presetn || !ce)
    (tick && run && src_sel == wkt_pkg::SRC_CORE && prescale == 4'h4) |=> !tick [*8];
  endproperty
  a_div16_gap: assert property (p_div16_gap) else $error("Divide-by-16 ticks came too close");

  property p_core_stop;
    @(posedge pclk) disable iff (!presetn)
    (ce && src_sel == wkt_pkg::SRC_CORE && core_clk_stopped) |=> !tick;
  endproperty
  a_core_stop: assert property (p_core_stop) else $error("Tick from stopped core clock");

endmodule : wkt_tick_gen
`default_nettype wire

// ===== rtl/wkt_count_step.sv
`default_nettype none
module wkt_count_step (
  input  wire logic [31:0]                    count,
  input  wire logic                           up,
  input  wire logic [wkt_pkg::CTL_FMT_W-1:0]  fmt,
  output logic      [31:0]                    count_nxt,
  output logic                                wrap
);

  // One time field: {carry, new value}
  function automatic logic [8:0] wkt_field_step(input logic [7:0] v, input logic [7:0] vmax,
                                                input logic up_dir);
    if (up_dir) begin
      if (v >= vmax) begin
        return {1'b1, 8'h00};
      end
      return {1'b0, v + 8'h01};
    end
    if (v == 8'h00) begin
      return {1'b1, vmax};
    end
    return {1'b0, v - 8'h01};
  endfunction : wkt_field_step

  logic [32:0] bin_sum;
  logic [8:0]  hund_s;
  logic [8:0]  sec_s;
  logic [8:0]  min_s;
  logic [8:0]  hr_s;
  logic [7:0]  hr_max;

  always_comb begin
    bin_sum = up ? ({1'b0, count} + 33'h000000001) : ({1'b0, count} - 33'h000000001);
    hr_max  = (fmt == wkt_pkg::FMT_H23) ? wkt_pkg::HR23_MAX : wkt_pkg::HR255_MAX;
    hund_s  = wkt_field_step(count[wkt_pkg::HUND_LSB +: wkt_pkg::FIELD_W], wkt_pkg::HUND_MAX, up);
    sec_s   = hund_s[8] ? wkt_field_step(count[wkt_pkg::SEC_LSB +: wkt_pkg::FIELD_W], wkt_pkg::SEC_MAX, up)
                        : {1'b0, count[wkt_pkg::SEC_LSB +: wkt_pkg::FIELD_W]};
    min_s   = sec_s[8] ? wkt_field_step(count[wkt_pkg::MIN_LSB +: wkt_pkg::FIELD_W], wkt_pkg::MIN_MAX, up)
                       : {1'b0, count[wkt_pkg::MIN_LSB +: wkt_pkg::FIELD_W]};
    hr_s    = min_s[8] ? wkt_field_step(count[wkt_pkg::HR_LSB +: wkt_pkg::FIELD_W], hr_max, up)
                       : {1'b0, count[wkt_pkg::HR_LSB +: wkt_pkg::FIELD_W]};
    if (fmt == wkt_pkg::FMT_H23 || fmt == wkt_pkg::FMT_H255) begin
      count_nxt = {hr_s[7:0], min_s[7:0], sec_s[7:0], hund_s[7:0]};
      wrap      = hr_s[8];
    end else begin
      // Binary; the reserved code behaves as binary
      count_nxt = bin_sum[31:0];
      wrap      = up ? bin_sum[32] : (count == 32'h00000000);
    end
  end

endmodule : wkt_count_step
`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk                    = 1'b0;
  logic        presetn                 = 1'b0;
  logic        ce                      = 1'b1;
  logic        psel                    = 1'b0;
  logic        penable                 = 1'b0;
  logic        pwrite                  = 1'b0;
  logic [31:0] paddr                   = 32'h00000000;
  logic [31:0] pwdata                  = 32'h00000000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        osc_clk_in              = 1'b0;
  logic        xtal_clk_in             = 1'b0;
  logic        uart_clk_in             = 1'b0;
  logic        core_clk_stopped        = 1'b0;
  logic [31:0] system_interrupt_enable = 32'h00000000;
  logic        capture_req             = 1'b0;
  logic        irq;
  int          fail_count              = 0;
  int          compares                = 0;
  int          cyc                     = 0;

  wkt_top wkt_top_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .osc_clk_in(osc_clk_in), .xtal_clk_in(xtal_clk_in), .uart_clk_in(uart_clk_in),
    .core_clk_stopped(core_clk_stopped), .system_interrupt_enable(system_interrupt_enable),
    .capture_req(capture_req), .irq(irq)
  );

  always #2.5 pclk = ~pclk;

  // Slow sources with periods of 8, 16 and 24 pclk cycles
  always @(posedge pclk) begin
    cyc         <= cyc + 1;
    osc_clk_in  <= (cyc % 8) >= 4;
    xtal_clk_in <= (cyc % 16) >= 8;
    uart_clk_in <= (cyc % 24) >= 12;
  end

  task automatic close_out();
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(r, exp);
  endtask : rdc

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    if (irq !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask : wait_irq

  function automatic logic [31:0] ctl(input logic [1:0] src, input logic up, input logic en,
                                      input logic per, input logic [1:0] fmt, input logic [3:0] pre);
    ctl = (32'(src) << wkt_pkg::CTL_SRC_LSB) | (32'(up) << wkt_pkg::CTL_UP_BIT) |
          (32'(en) << wkt_pkg::CTL_EN_BIT) | (32'(per) << wkt_pkg::CTL_PERIODIC_BIT) |
          (32'(fmt) << wkt_pkg::CTL_FMT_LSB) | 32'(pre);
  endfunction : ctl

  // One tick of the counter in any format, carrying field by field
  function automatic logic [31:0] tstep(input logic [31:0] v, input logic up, input logic [1:0] fmt);
    logic [7:0] mx [4];
    logic [7:0] f;
    logic       go;
    if (fmt[1] == 1'b0) return up ? v + 32'h00000001 : v - 32'h00000001;
    mx[0] = wkt_pkg::HUND_MAX;
    mx[1] = wkt_pkg::SEC_MAX;
    mx[2] = wkt_pkg::MIN_MAX;
    mx[3] = (fmt == wkt_pkg::FMT_H23) ? wkt_pkg::HR23_MAX : wkt_pkg::HR255_MAX;
    go = 1'b1;
    for (int i = 0; i < 4; i++) begin
      f = v[8*i +: 8];
      if (go && up) begin
        go = (f == mx[i]);
        f  = go ? 8'h00 : f + 8'h01;
      end else if (go) begin
        go = (f == 8'h00);
        f  = go ? mx[i] : f - 8'h01;
      end
      v[8*i +: 8] = f;
    end
    return v;
  endfunction : tstep

  logic [31:0] addrs [8] = '{wkt_pkg::LOAD_ADDR, wkt_pkg::COUNT_ADDR, wkt_pkg::CONTROL_ADDR,
                             wkt_pkg::CLEAR_ADDR, wkt_pkg::STATUS_ADDR, wkt_pkg::INT_CLEAR_ADDR,
                             wkt_pkg::INT_EN_ADDR, wkt_pkg::CAPTURE_ADDR};
  logic [1:0]  srcs [4]  = '{wkt_pkg::SRC_OSC, wkt_pkg::SRC_CORE, wkt_pkg::SRC_XTAL, wkt_pkg::SRC_UART};
  logic [31:0] src_n [4] = '{32'h6, 32'h0, 32'h3, 32'h2};
  logic [3:0]  pres [4]  = '{4'h0, 4'h4, 4'h8, 4'hf};
  logic [1:0]  t_fmt [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic        t_up [6]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [31:0] t_ld [6]  = '{32'h00000100, 32'h00000100, 32'h0000fffe, 32'h163b3b5a,
                             32'h01000005, 32'h0a3b3b5a};

  initial begin
    logic [31:0] r;
    logic [31:0] a;
    logic [31:0] ld;
    logic        e;
    int          w;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, addrs[i], 32'h00000000, r, e);
      check(r, wkt_pkg::WORD_RESET);
      check({31'h0, e}, 32'h0);
    end
    apb(1'b0, 32'hffff0360, 32'h00000000, r, e);
    check({31'h0, e}, 32'h1);
    wr(wkt_pkg::LOAD_ADDR, 32'ha5a55a5a);
    rdc(wkt_pkg::LOAD_ADDR, 32'ha5a55a5a);
    wr(wkt_pkg::CONTROL_ADDR, 32'hffffffff);
    rdc(wkt_pkg::CONTROL_ADDR, wkt_pkg::CTL_WMASK);
    wr(wkt_pkg::CONTROL_ADDR, 32'h00000000);
    wr(wkt_pkg::COUNT_ADDR, 32'h00001234);
    rdc(wkt_pkg::COUNT_ADDR, 32'h00000000);
    wr(wkt_pkg::LOAD_ADDR, 32'h00000055);
    wr(wkt_pkg::CLEAR_ADDR, 32'h000000ff);
    rdc(wkt_pkg::COUNT_ADDR, 32'h00000055);
    // Capture is gated by the system enable bit
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk) system_interrupt_enable <= i ? 32'h00000010 : 32'h00000000;
      @(posedge pclk) capture_req <= 1'b1;
      @(posedge pclk) capture_req <= 1'b0;
      repeat (2) @(posedge pclk);
      rdc(wkt_pkg::CAPTURE_ADDR, i ? 32'h00000055 : 32'h00000000);
      rdc(wkt_pkg::STATUS_ADDR, i ? 32'h00000002 : 32'h00000000);
    end
    wr(wkt_pkg::INT_CLEAR_ADDR, 32'h00000002);
    // Each source over 48 cycles, core clock stopped
    @(posedge pclk) core_clk_stopped <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(wkt_pkg::CONTROL_ADDR, ctl(srcs[i], 1'b1, 1'b1, 1'b0, 2'h0, 4'h0));
      repeat (10) @(posedge pclk);
      rd(wkt_pkg::COUNT_ADDR, a);
      repeat (45) @(posedge pclk);
      rd(wkt_pkg::COUNT_ADDR, r);
      check(r - a, src_n[i]);
    end
    @(posedge pclk) core_clk_stopped <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      w = (pres[i] == 4'hf) ? 32768 : (4 << pres[i]);
      wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, 1'b0, 1'b1, 1'b0, 2'h0, pres[i]));
      repeat (8) @(posedge pclk);
      rd(wkt_pkg::COUNT_ADDR, a);
      repeat (w - 3) @(posedge pclk);
      rd(wkt_pkg::COUNT_ADDR, r);
      check(a - r, 32'(w >> pres[i]));
    end
    wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, 1'b1, 1'b1, 1'b0, 2'h0, 4'h0));
    rd(wkt_pkg::COUNT_ADDR, a);
    @(posedge pclk) ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    rd(wkt_pkg::COUNT_ADDR, r);
    check(r - a, 32'h00000004);
    wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0));
    rd(wkt_pkg::COUNT_ADDR, a);
    repeat (20) @(posedge pclk);
    rdc(wkt_pkg::COUNT_ADDR, a);
    // Wrap and interrupt: periodic down, periodic up, free-running down
    wr(wkt_pkg::INT_EN_ADDR, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      ld = (i == 1) ? 32'hfffffffa : 32'h00000005;
      wr(wkt_pkg::LOAD_ADDR, ld);
      wr(wkt_pkg::CLEAR_ADDR, 32'h00000000);
      wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, i == 1, 1'b1, i < 2, 2'h0, 4'h0));
      wait_irq();
      rd(wkt_pkg::COUNT_ADDR, r);
      check({31'h0, (i == 2) ? r > ld : (i == 1) ? r >= ld : r <= ld}, 32'h1);
      wr(wkt_pkg::CONTROL_ADDR, 32'h00000000);
      rdc(wkt_pkg::STATUS_ADDR, 32'h00000001);
      wr(wkt_pkg::INT_EN_ADDR, 32'h00000000);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      wr(wkt_pkg::INT_EN_ADDR, 32'h00000001);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      if (i == 1) wr(wkt_pkg::INT_CLEAR_ADDR, 32'h00000001);
      else wr(wkt_pkg::CLEAR_ADDR, 32'h000000a5);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rdc(wkt_pkg::STATUS_ADDR, 32'h00000000);
      if (i != 1) rdc(wkt_pkg::COUNT_ADDR, ld);
    end
    // Chains of reads three ticks apart in every format
    for (int i = 0; i < 6; i++) begin
      wr(wkt_pkg::LOAD_ADDR, t_ld[i]);
      wr(wkt_pkg::CLEAR_ADDR, 32'h00000000);
      wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, t_up[i], 1'b1, 1'b0, t_fmt[i], 4'h0));
      rd(wkt_pkg::COUNT_ADDR, a);
      for (int j = 0; j < 5; j++) begin
        rd(wkt_pkg::COUNT_ADDR, r);
        check(r, tstep(tstep(tstep(a, t_up[i], t_fmt[i]), t_up[i], t_fmt[i]), t_up[i], t_fmt[i]));
        a = r;
      end
      wr(wkt_pkg::CONTROL_ADDR, 32'h00000000);
    end
    wr(wkt_pkg::LOAD_ADDR, 32'h173b3b63);
    wr(wkt_pkg::CLEAR_ADDR, 32'h00000000);
    wr(wkt_pkg::CONTROL_ADDR, ctl(wkt_pkg::SRC_CORE, 1'b1, 1'b1, 1'b0, 2'h2, 4'h8));
    rd(wkt_pkg::COUNT_ADDR, a);
    repeat (253) @(posedge pclk);
    rd(wkt_pkg::COUNT_ADDR, r);
    check(r, tstep(a, 1'b1, 2'h2));
    rdc(wkt_pkg::STATUS_ADDR, 32'h00000001);
    close_out();
  end
endmodule : testbench
`default_nettype wire
